// >>> include/cfg_status_pkg.sv
package cfg_status_pkg;

  // Configuration byte offsets.
  localparam logic [7:0] STATUS_LO_OFS = 8'h06;
  localparam logic [7:0] STATUS_HI_OFS = 8'h07;
  localparam logic [7:0] REVISION_OFS = 8'h08;
  localparam logic [7:0] PROG_IF_OFS = 8'h09;
  localparam logic [7:0] SUBCLASS_OFS = 8'h0a;
  localparam logic [7:0] BASECLASS_OFS = 8'h0b;
  localparam logic [7:0] STATUS_DWORD_OFS = 8'h04;
  localparam logic [7:0] CLASS_DWORD_OFS = 8'h08;
  localparam logic [7:0] COMMAND_LO_OFS = 8'h04;
  localparam logic [7:0] COMMAND_HI_OFS = 8'h05;

  // Status bit positions.
  localparam int PARITY_ERROR_DETECTED_BIT = 15;
  localparam int SYSTEM_ERROR_SIGNALED_BIT = 14;
  localparam int MASTER_ABORT_FLAG_BIT = 13;
  localparam int TARGET_ABORT_RECEIVED_BIT = 12;
  localparam int TARGET_ABORT_SIGNALED_BIT = 11;
  localparam int DATA_PARITY_ERROR_REPORTED_BIT = 8;
  localparam int FLAG_COUNT = 6;

  // Command bit positions for the two enables.
  localparam int PARITY_ERROR_RESPONSE_ENABLE_BIT = 6;
  localparam int SYSTEM_ERROR_ENABLE_BIT = 8;

  // Fixed status content: devsel timing 01, back-to-back capable 1, others 0.
  localparam logic [1:0] DEVSEL_TIMING_CODE = 2'h1;
  localparam logic [15:0] STATUS_FIXED = 16'h0280;
  localparam logic [15:0] STATUS_RESET = 16'h0280;
  localparam logic [7:0] PROG_IF_VALUE = 8'h00;
  localparam logic [7:0] SUBCLASS_VALUE = 8'h01;
  localparam logic [7:0] BASECLASS_VALUE = 8'h06;

endpackage : cfg_status_pkg

// >>> hw/error_flag.sv
`timescale 1ns/1ps
// One write-one-to-clear sticky flag; a set in the clearing cycle wins.
module error_flag (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      flag <= 1'b0;
    end else if (set_pulse) begin
      flag <= 1'b1;
    end else if (clear_pulse) begin
      flag <= 1'b0;
    end
  end
endmodule : error_flag

// >>> hw/cfg_status_regs.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Parity error pin activity sets bit 15, regardless of parity response enable.
// - Error flags stay set until software writes 1 to that bit.
// - Bit 14 sets when system error enabled and this function asserts system error.
// - Bit 13 sets on master abort of cycles run for LPC masters or DMA.
// - Bit 12 sets when a target aborts a cycle started for LPC master or DMA.
// - Bit 11 sets when we signal target abort on a claimed cycle.
// - Bits 10:9 are read-only and read 01, medium devsel timing.
// - Bit 8 sets when initiator, parity error seen or driven, and response enabled.
// - Bit 7 reads 1: target accepts fast back-to-back transactions.
// - Bits 6 and 5 read 0; bits 4:0 reserved, read 0.
// - Status register at offset 06h-07h reads 0280h after reset.
// - Read-only revision byte sits at offset 08h, value set per stepping.
// - Programming interface byte at 09h reads 00h.
// - Sub-class byte at 0Ah reads 01h.
// - Base-class byte at 0Bh reads 06h.
// - Parity error response enable, command bit 6, gates parity error action.
// - System error enable, command bit 8, gates system error assertion.
//////////////////////////////////////////////////////////////////////////////
// Configuration access is a dword port: CFG_OFS selects a dword (low two bits
// ignored), byte enables qualify writes. Read data is registered one cycle
// after CFG_RD. Event inputs are single-cycle pulses from logic on this clock.
module cfg_status_regs
  import cfg_status_pkg::*;
#(
  parameter logic [7:0] REVISION_VALUE = 8'h00
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CFG_RD,
  input wire logic CFG_WR,
  input wire logic [7:0] CFG_OFS,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic PARITY_ERROR_SEEN,
  input wire logic SYSTEM_ERROR_REQ,
  input wire logic MASTER_ABORT_EVT,
  input wire logic TARGET_ABORT_RX_EVT,
  input wire logic TARGET_ABORT_TX_EVT,
  input wire logic INITIATOR_PARITY_EVT,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  output logic PARITY_ERROR_RESPONSE_ENABLE,
  output logic SYSTEM_ERROR_ENABLE,
  output logic SYSTEM_ERROR_OUT
);

  logic per_reg;
  logic system_error_enable_reg;
  logic [FLAG_COUNT-1:0] set_vec;
  logic [FLAG_COUNT-1:0] clr_vec;
  logic [FLAG_COUNT-1:0] flag_vec;
  logic [15:0] status_word;
  logic [31:0] rdata_next;
  logic wr_status_hi;
  logic wr_status_lo;
  logic wr_cmd_lo;
  logic wr_cmd_hi;

  function automatic logic hit(input logic [7:0] ofs, input logic [7:0] dword);
    hit = (ofs[7:2] == dword[7:2]);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // Write decode. Only the enables and the clear-on-one flags are writable.
  always_comb begin
    wr_cmd_lo = 1'b0;
    wr_cmd_hi = 1'b0;
    wr_status_lo = 1'b0;
    wr_status_hi = 1'b0;
    if (CFG_WR && hit(CFG_OFS, STATUS_DWORD_OFS)) begin
      wr_cmd_lo = CFG_BE[COMMAND_LO_OFS[1:0]];
      wr_cmd_hi = CFG_BE[COMMAND_HI_OFS[1:0]];
      wr_status_lo = CFG_BE[STATUS_LO_OFS[1:0]];
      wr_status_hi = CFG_BE[STATUS_HI_OFS[1:0]];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      per_reg <= 1'b0;
    end else if (wr_cmd_lo) begin
      per_reg <= CFG_WDATA[PARITY_ERROR_RESPONSE_ENABLE_BIT];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      system_error_enable_reg <= 1'b0;
    end else if (wr_cmd_hi) begin
      system_error_enable_reg <= CFG_WDATA[SYSTEM_ERROR_ENABLE_BIT];
    end
  end

  // The enables move only on a write that carries their byte lane.
  per_load_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    wr_cmd_lo |=> per_reg == $past(CFG_WDATA[PARITY_ERROR_RESPONSE_ENABLE_BIT])
  ) else $error("parity response enable not loaded");

  per_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !wr_cmd_lo |=> per_reg == $past(per_reg)
  ) else $error("parity response enable moved without a write");

  serr_load_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    wr_cmd_hi |=> system_error_enable_reg == $past(CFG_WDATA[SYSTEM_ERROR_ENABLE_BIT])
  ) else $error("system error enable not loaded");

  serr_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !wr_cmd_hi |=> system_error_enable_reg == $past(system_error_enable_reg)
  ) else $error("system error enable moved without a write");

  //////////////////////////////////////////////////////////////////////////////
  // Event sources. Flag order: 15,14,13,12,11,8 map to vector 5..0.
  always_comb begin
    set_vec[5] = PARITY_ERROR_SEEN;
    set_vec[4] = SYSTEM_ERROR_REQ && system_error_enable_reg;
    set_vec[3] = MASTER_ABORT_EVT;
    set_vec[2] = TARGET_ABORT_RX_EVT;
    set_vec[1] = TARGET_ABORT_TX_EVT;
    set_vec[0] = INITIATOR_PARITY_EVT && per_reg;
    // Status dword writes land in the upper half of the data word.
    clr_vec[5] = wr_status_hi && CFG_WDATA[16 + PARITY_ERROR_DETECTED_BIT];
    clr_vec[4] = wr_status_hi && CFG_WDATA[16 + SYSTEM_ERROR_SIGNALED_BIT];
    clr_vec[3] = wr_status_hi && CFG_WDATA[16 + MASTER_ABORT_FLAG_BIT];
    clr_vec[2] = wr_status_hi && CFG_WDATA[16 + TARGET_ABORT_RECEIVED_BIT];
    clr_vec[1] = wr_status_hi && CFG_WDATA[16 + TARGET_ABORT_SIGNALED_BIT];
    clr_vec[0] = wr_status_hi && CFG_WDATA[16 + DATA_PARITY_ERROR_REPORTED_BIT];
  end

  // Byte lane 2 holds only read-only status bits, so it must never clear a flag.
  lane_two_inert_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (wr_status_lo && !wr_status_hi) |=> ($past(flag_vec) & ~flag_vec) == '0
  ) else $error("status low lane cleared a flag");

  parity_ungated_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (PARITY_ERROR_SEEN && !per_reg) |=> flag_vec[5]
  ) else $error("parity flag gated by response enable");

  data_parity_error_reported_masked_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (INITIATOR_PARITY_EVT && !per_reg && !flag_vec[0]) |=> !flag_vec[0]
  ) else $error("data parity flag set while response disabled");

  data_parity_error_reported_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (INITIATOR_PARITY_EVT && per_reg) |=> flag_vec[0]
  ) else $error("data parity flag missed");

  sse_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (SYSTEM_ERROR_REQ && system_error_enable_reg) |=> flag_vec[4]
  ) else $error("system error flag missed");

  genvar g;
  generate
    for (g = 0; g < FLAG_COUNT; g++) begin : flag_gen
      error_flag u_flag (
        .CLK_SYS(CLK_SYS),
        .RSTN(RSTN),
        .set_pulse(set_vec[g]),
        .clear_pulse(clr_vec[g]),
        .flag(flag_vec[g])
      );

      flag_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        set_vec[g] |=> flag_vec[g]
      ) else $error("flag event lost");

      flag_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (clr_vec[g] && !set_vec[g]) |=> !flag_vec[g]
      ) else $error("flag not cleared");

      flag_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (flag_vec[g] && !clr_vec[g]) |=> flag_vec[g]
      ) else $error("flag dropped without a clear");

      flag_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (!flag_vec[g] && !set_vec[g]) |=> !flag_vec[g]
      ) else $error("flag set without an event");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Status assembly: fixed bits come from the constant, flags are OR-ed in.
  always_comb begin
    status_word = STATUS_FIXED;
    status_word[PARITY_ERROR_DETECTED_BIT] = flag_vec[5];
    status_word[SYSTEM_ERROR_SIGNALED_BIT] = flag_vec[4];
    status_word[MASTER_ABORT_FLAG_BIT] = flag_vec[3];
    status_word[TARGET_ABORT_RECEIVED_BIT] = flag_vec[2];
    status_word[TARGET_ABORT_SIGNALED_BIT] = flag_vec[1];
    status_word[DATA_PARITY_ERROR_REPORTED_BIT] = flag_vec[0];
  end

  reset_status_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $rose(RSTN) |-> status_word == STATUS_RESET
  ) else $error("status not at reset value");

  // Unmapped dwords read as zero; the command word shows only its two enables.
  always_comb begin
    rdata_next = 32'h0;
    if (hit(CFG_OFS, STATUS_DWORD_OFS)) begin
      rdata_next[31:16] = status_word;
      rdata_next[PARITY_ERROR_RESPONSE_ENABLE_BIT] = per_reg;
      rdata_next[SYSTEM_ERROR_ENABLE_BIT] = system_error_enable_reg;
    end else if (hit(CFG_OFS, CLASS_DWORD_OFS)) begin
      rdata_next = {BASECLASS_VALUE, SUBCLASS_VALUE, PROG_IF_VALUE, REVISION_VALUE};
    end
  end

  // Read data holds between reads, so a slow host may still pick it up late.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CFG_RDATA <= 32'h0;
    end else if (CFG_RD) begin
      CFG_RDATA <= rdata_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD;
    end
  end

  status_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_RD && hit(CFG_OFS, STATUS_DWORD_OFS)) |=> CFG_RDATA[31:16] == $past(status_word)
  ) else $error("status read data");

  revision_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_RD && hit(CFG_OFS, CLASS_DWORD_OFS)) |=> CFG_RDATA[7:0] == REVISION_VALUE
  ) else $error("revision read data");

  prog_if_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_RD && hit(CFG_OFS, CLASS_DWORD_OFS)) |=> CFG_RDATA[15:8] == PROG_IF_VALUE
  ) else $error("programming interface read data");

  base_class_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_RD && hit(CFG_OFS, CLASS_DWORD_OFS)) |=> CFG_RDATA[31:24] == BASECLASS_VALUE
  ) else $error("base class read data");

  unmapped_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_RD && !hit(CFG_OFS, STATUS_DWORD_OFS) && !hit(CFG_OFS, CLASS_DWORD_OFS)) |=> CFG_RDATA == 32'h0
  ) else $error("unmapped read not zero");

  // System error pin is a registered pulse, suppressed while disabled.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SYSTEM_ERROR_OUT <= 1'b0;
    end else begin
      SYSTEM_ERROR_OUT <= set_vec[4];
    end
  end

  // The enable outputs are registered copies and trail the command word by one cycle.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PARITY_ERROR_RESPONSE_ENABLE <= 1'b0;
    end else begin
      PARITY_ERROR_RESPONSE_ENABLE <= per_reg;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SYSTEM_ERROR_ENABLE <= 1'b0;
    end else begin
      SYSTEM_ERROR_ENABLE <= system_error_enable_reg;
    end
  end

  serr_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    1'b1 |=> SYSTEM_ERROR_OUT == $past(set_vec[4])
  ) else $error("system error pulse wrong");

  serr_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !system_error_enable_reg |=> !SYSTEM_ERROR_OUT
  ) else $error("system error while disabled");

  enable_copy_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    1'b1 |=> PARITY_ERROR_RESPONSE_ENABLE == $past(per_reg) && SYSTEM_ERROR_ENABLE == $past(system_error_enable_reg)
  ) else $error("enable outputs do not follow the command word");

  //////////////////////////////////////////////////////////////////////////////
  dpe_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    PARITY_ERROR_SEEN |=> flag_vec[5]) else $error("parity flag not set");
  hold_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (flag_vec[3] && !clr_vec[3]) |=> flag_vec[3]) else $error("flag lost");
  sse_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!flag_vec[4] && !(SYSTEM_ERROR_REQ && system_error_enable_reg)) |=> !flag_vec[4]) else $error("sse spurious");
  rma_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    MASTER_ABORT_EVT |=> flag_vec[3]) else $error("master abort missed");
  rta_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    TARGET_ABORT_RX_EVT |=> flag_vec[2]) else $error("rx abort missed");
  sta_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    TARGET_ABORT_TX_EVT |=> flag_vec[1]) else $error("tx abort missed");
  fixed_bits_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    status_word[10:9] == DEVSEL_TIMING_CODE && status_word[7:0] == 8'h80) else $error("fixed bits");
  data_parity_error_reported_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!flag_vec[0] && !(INITIATOR_PARITY_EVT && per_reg)) |=> !flag_vec[0]) else $error("data_parity_error_reported spurious");
  class_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CFG_RD && hit(CFG_OFS, CLASS_DWORD_OFS)) |=> CFG_RDATA[31:8] == 24'h060100) else $error("class");
  set_wins_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (set_vec[1] && clr_vec[1]) |=> flag_vec[1]) else $error("set lost");

endmodule : cfg_status_regs

// >>> testbench/cfg_host_model.sv
`timescale 1ns/1ps
// Configuration host: a released bus drops rd and wr and shows the inverse of its last ofs, be and wdata, so stale data is never read as live.
module cfg_host_model (
  input wire logic clk,
  output logic rd,
  output logic wr,
  output logic [7:0] ofs,
  output logic [3:0] be,
  output logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    ofs = 8'h00;
    be = 4'h0;
    wdata = 32'h0;
  end

  task automatic xfer(input logic r, input logic w, input logic [7:0] o, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] got, output logic gv);
    @(posedge clk);
    rd <= r;
    wr <= w;
    ofs <= o;
    be <= b;
    wdata <= d;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    ofs <= ~o;
    be <= ~b;
    wdata <= ~d;
    #1;
    got = rdata;
    gv = rvalid;
  endtask : xfer
endmodule : cfg_host_model

// >>> testbench/lpc_bridge_pci_status_class_regs_tb_top.sv
`timescale 1ns/1ps
module lpc_bridge_pci_status_class_regs_tb_top;
  import cfg_status_pkg::*;
  localparam logic [7:0] REV_TEST = 8'h5a;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cfg_rd, cfg_wr, rvalid, pen_o, sen_o, serr_o;
  logic [7:0] ofs;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  logic [5:0] evt = 6'h0;
  int err_total = 0;
  int check_count = 0;
  int st = 0;
  int pen = 0;
  int sen = 0;
  logic [31:0] exp_q[$];

  always #25 clk_sys = ~clk_sys;

  cfg_host_model host (.clk(clk_sys), .rd(cfg_rd), .wr(cfg_wr), .ofs(ofs), .be(be), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));
  cfg_status_regs #(.REVISION_VALUE(REV_TEST)) uut (.CLK_SYS(clk_sys), .RSTN(rstn), .CFG_RD(cfg_rd),
    .CFG_WR(cfg_wr), .CFG_OFS(ofs), .CFG_BE(be), .CFG_WDATA(wdata), .PARITY_ERROR_SEEN(evt[5]),
    .SYSTEM_ERROR_REQ(evt[4]), .MASTER_ABORT_EVT(evt[3]), .TARGET_ABORT_RX_EVT(evt[2]),
    .TARGET_ABORT_TX_EVT(evt[1]), .INITIATOR_PARITY_EVT(evt[0]), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
    .PARITY_ERROR_RESPONSE_ENABLE(pen_o), .SYSTEM_ERROR_ENABLE(sen_o), .SYSTEM_ERROR_OUT(serr_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  function automatic logic [31:0] exp04();
    return {16'(st) | 16'h0280, 7'h0, 1'(sen), 1'b0, 1'(pen), 6'h0};
  endfunction : exp04

  ////////////////////////////////////////////////////////////////////////
  // Events are judged against the enables as they stood before this write lands.
  task automatic step(input logic [5:0] e, input logic w, input logic [7:0] o, input logic [3:0] b,
                      input logic [31:0] d);
    logic [31:0] got;
    logic gv;
    logic hit;
    int clr;
    fork
      host.xfer(1'b0, w, o, b, d, got, gv);
      begin
        @(posedge clk_sys);
        evt <= e;
        @(posedge clk_sys);
        evt <= 6'h0;
      end
    join
    hit = w && o[7:2] == 6'h01;
    clr = (hit && b[3]) ? ((int'(d[31:24]) << 8) & 'hf900) : 0;
    st = (st & ~clr) | (int'(e[5]) << 15) | (int'(e[4] && sen != 0) << 14) | (int'(e[3]) << 13)
      | (int'(e[2]) << 12) | (int'(e[1]) << 11) | (int'(e[0] && pen != 0) << 8);
    chk(32'(serr_o), 32'(e[4] && sen != 0), "system error out");
    // The enable outputs are registered copies, so they still show the values before this write.
    chk(32'({pen_o, sen_o}), 32'({1'(pen), 1'(sen)}), "enables");
    if (hit && b[0]) pen = int'(d[6]);
    if (hit && b[1]) sen = int'(d[8]);
  endtask : step

  task automatic rd_chk(input logic [7:0] o, input logic [31:0] exp);
    logic [31:0] got;
    logic gv;
    exp_q.push_back(exp);
    host.xfer(1'b1, 1'b0, o, 4'h0, 32'h0, got, gv);
    chk(32'(gv), 32'h1, "read valid");
    chk(got, exp_q.pop_front(), "read data");
  endtask : rd_chk

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end

  initial begin
    void'($urandom(10213));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk(8'h06, 32'h0280_0000);
    rd_chk(8'h0b, {8'h06, 8'h01, 8'h00, REV_TEST});
    rd_chk(8'h10, 32'h0);
    step(6'h00, 1'b1, 8'h08, 4'hf, 32'hffff_ffff);
    rd_chk(8'h09, {8'h06, 8'h01, 8'h00, REV_TEST});
    step(6'h3f, 1'b1, 8'h04, 4'hc, 32'h067f_0000);
    rd_chk(8'h04, exp04());
    step(6'h00, 1'b1, 8'h04, 4'h3, 32'h0000_0140);
    step(6'h3f, 1'b1, 8'h07, 4'h8, 32'hffff_0000);
    rd_chk(8'h04, exp04());
    for (int i = 0; i < 300; i++) begin
      step(6'($urandom & $urandom), 1'($urandom), ($urandom % 3 == 0) ? 8'h08 : {6'h01, 2'($urandom)},
        4'($urandom), $urandom);
      rd_chk(8'h04, exp04());
      if (i % 50 == 0) rd_chk(8'h0a, {8'h06, 8'h01, 8'h00, REV_TEST});
    end
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    st = 0;
    pen = 0;
    sen = 0;
    rd_chk(8'h06, exp04());
    end_of_test();
  end
endmodule : lpc_bridge_pci_status_class_regs_tb_top
